// *** core/fpec_pkg.sv ***
/*
  Package for the flash program/erase controller: array geometry, command
  codes, timing figures and the request/answer carriers.
  Assumes a single 50 MHz clock domain.
*/
package fpec_pkg;

  // ==========================================================
  // geometry
  localparam int SECTOR_COUNT = 4;
  localparam int SECTOR_BYTES = 256;
  localparam int PAGE_BYTES = 16;
  localparam int ARRAY_BYTES = SECTOR_COUNT * SECTOR_BYTES;
  localparam int ADDR_W = 10;
  localparam int PAGE_IDX_W = 4;
  localparam int CFG_COUNT = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;

  // ==========================================================
  // crc
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  // ==========================================================
  // commands
  typedef enum logic [3:0] {
    FPEC_CMD_NONE,
    FPEC_CMD_LOAD,
    FPEC_CMD_PROGRAM,
    FPEC_CMD_ERASE_BYTE,
    FPEC_CMD_ERASE_PAGE,
    FPEC_CMD_ERASE_SECTOR,
    FPEC_CMD_ERASE_CHIP,
    FPEC_CMD_CRC_SECTOR,
    FPEC_CMD_CRC_ALL,
    FPEC_CMD_CFG_WRITE,
    FPEC_CMD_CFG_ERASE
  } fpec_cmd_type;

  typedef struct packed {
    fpec_cmd_type cmd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fpec_req_type;

  typedef struct packed {
    logic busy;
    logic done;
    logic refused;
    logic [31:0] crc;
  } fpec_stat_type;

  // ==========================================================
  // serial frame: 4-bit command, 10-bit address, 8-bit data, msb first
  localparam int SER_FRAME_BITS = 22;

endpackage

// *** core/fpec_crc32.sv ***
/*
  One-byte step of a 32-bit CRC, msb first.
  Assumes the caller registers the result; purely combinational.
*/
module fpec_crc32
  import fpec_pkg::*;
(
  input wire logic [31:0] crc_in, // running value
  input wire logic [7:0] byte_in, // next byte
  output logic [31:0] crc_out // updated value
);
  import fpec_pkg::*;

  // ==========================================================
  // body
  always_comb
  begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[31] ^ byte_in[i])
        c = {c[30:0], 1'b0} ^ CRC_POLY;
      else
        c = {c[30:0], 1'b0};
    end
    crc_out = c;
  end
endmodule // fpec_crc32

// *** core/fpec_ctrl.sv ***
/*
  Flash program/erase controller with a flop-based 1 KB array, page
  register, configuration and sector security bytes, CRC verify, a
  firmware command port and a two-wire serial programming path.
  Assumes serial pins come from outside and are synchronised here.
*/
// What this block does
// - four 256-byte sectors of 16-byte pages
// - erase one sector, page or byte
// - whole-array erase in one command
// - page register programs one to sixteen bytes
// - internal timing, each operation within 2 ms
// - configuration bytes erasable and reprogrammable
// - crc32 over one sector or all
// - firmware port: control/status, data, two address
// - serial clock/data link under reset accepts commands
// - every byte read, erased, written alone
// - code reads refused in secured sectors
// - four security bytes, one per sector
// - power-up config byte applied at power-up only
module fpec_ctrl
  import fpec_pkg::*;
#(
  parameter int OP_WAIT = OP_CYCLES
)(
  input wire logic clk_in, // 50 MHz clock
  input wire logic reset_in, // async reset, active high
  input wire logic power_on_in, // one-cycle power-up pulse
  input wire fpec_pkg::fpec_req_type fw_req_in, // firmware command
  input wire logic fw_valid_in, // firmware command strobe
  input wire logic [fpec_pkg::ADDR_W-1:0] fw_addr_hi_lo_in, // address
  output fpec_pkg::fpec_stat_type fw_stat_out, // control/status view
  input wire logic prog_rst_in, // programmer holds reset pin
  input wire logic ser_clk_in, // serial clock pin
  input wire logic ser_data_in, // serial data pin, input side
  output logic ser_data_out, // serial data pin, output side
  output logic ser_data_oe_out, // serial data drive enable
  input wire logic code_rd_in, // code read instruction strobe
  input wire logic [fpec_pkg::ADDR_W-1:0] code_addr_in, // read address
  output logic [7:0] code_data_out, // read data, erased if refused
  output logic code_refused_out, // read hit a secured sector
  output logic [7:0] power_up_config_byte_out // latched features
);
  import fpec_pkg::*;

  localparam int CNT_W = $clog2(OP_WAIT + 1);
  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(OP_WAIT - 1);
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(ARRAY_BYTES - 1);
  localparam logic [7:0] SEC_LAST = 8'(SECTOR_BYTES - 1);
  localparam logic [ADDR_W-1:0] SEC_SPAN = ADDR_W'(SECTOR_BYTES - 1);
  localparam logic [ADDR_W-1:0] PAGE_SPAN = ADDR_W'(PAGE_BYTES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CRC} fpec_state_type;

  // ==========================================================
  // storage
  logic [7:0] mem_q [ARRAY_BYTES];
  logic [7:0] page_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_ld_q;
  logic [7:0] cfg_q [CFG_COUNT]; // 0 = power-up config, 1 boot, 2-3 vector
  logic [7:0] sec_q [SECTOR_COUNT];
  fpec_state_type state_q;
  fpec_req_type op_q;
  logic [CNT_W-1:0] cnt_q;
  logic [ADDR_W-1:0] crc_addr_q;
  logic [ADDR_W-1:0] crc_end_q;
  logic [31:0] crc_q;
  logic done_q;
  logic refused_q;

  function automatic logic [1:0] sector_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:ADDR_W-2];
  endfunction

  // ==========================================================
  // serial programming path
  logic sclk_m_q, sclk_s_q, sclk_p_q, sdat_m_q, sdat_s_q;
  logic [SER_FRAME_BITS-1:0] ser_sh_q;
  logic [4:0] ser_cnt_q;
  logic ser_valid_q;
  wire ser_rise = sclk_s_q & ~sclk_p_q;
  wire ser_full = (ser_cnt_q == 5'(SER_FRAME_BITS - 1));
  wire fpec_req_type ser_req = ser_sh_q;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      sdat_m_q <= 1'b0;
      sdat_s_q <= 1'b0;
      ser_sh_q <= '0;
      ser_cnt_q <= '0;
      ser_valid_q <= 1'b0;
    end
    else
    begin
      sclk_m_q <= ser_clk_in;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      sdat_m_q <= ser_data_in;
      sdat_s_q <= sdat_m_q;
      ser_valid_q <= prog_rst_in & ser_rise & ser_full;
      if (!prog_rst_in)
        ser_cnt_q <= '0;
      else if (ser_rise)
      begin
        ser_sh_q <= {ser_sh_q[SER_FRAME_BITS-2:0], sdat_s_q};
        ser_cnt_q <= ser_full ? 5'h00 : ser_cnt_q + 5'h01;
      end
    end
  end

  // ==========================================================
  // command selection: serial path owns the array while in reset
  wire req_valid = prog_rst_in ? ser_valid_q : fw_valid_in;
  fpec_req_type req;
  assign req = prog_rst_in ? ser_req
                           : fpec_req_type'{cmd: fw_req_in.cmd,
                               addr: fw_addr_hi_lo_in,
                               data: fw_req_in.data};
  wire idle = (state_q == ST_IDLE);
  wire take = req_valid & idle & (req.cmd != FPEC_CMD_NONE);
  wire is_load = (req.cmd == FPEC_CMD_LOAD);
  wire [PAGE_IDX_W-1:0] req_pidx = req.addr[PAGE_IDX_W-1:0];
  wire [PAGE_IDX_W-1:0] op_pidx = op_q.addr[PAGE_IDX_W-1:0];
  wire [ADDR_W-1:0] sec_base = {sector_of(op_q.addr), 8'h00};
  wire [ADDR_W-1:0] page_base = {op_q.addr[ADDR_W-1:PAGE_IDX_W], 4'h0};
  wire finish = (state_q == ST_WAIT) & (cnt_q == WAIT_LAST);
  wire crc_last = (crc_addr_q == crc_end_q);
  logic [31:0] crc_next;

  fpec_crc32 u_crc (
    .crc_in (crc_q),
    .byte_in (mem_q[crc_addr_q]),
    .crc_out (crc_next)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q <= ST_IDLE;
      op_q <= '0;
      cnt_q <= '0;
      crc_addr_q <= '0;
      crc_end_q <= '0;
      crc_q <= CRC_INIT;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      page_ld_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      refused_q <= req_valid & ~idle;
      case (state_q)
        ST_IDLE:
        begin
          if (take && is_load)
          begin
            page_ld_q[req_pidx] <= 1'b1;
            done_q <= 1'b1;
          end
          else if (take)
          begin
            op_q <= req;
            cnt_q <= '0;
            crc_q <= CRC_INIT;
            if (req.cmd == FPEC_CMD_CRC_ALL)
            begin
              crc_addr_q <= '0;
              crc_end_q <= ADDR_LAST;
              state_q <= ST_CRC;
            end
            else if (req.cmd == FPEC_CMD_CRC_SECTOR)
            begin
              crc_addr_q <= {sector_of(req.addr), 8'h00};
              crc_end_q <= {sector_of(req.addr), SEC_LAST};
              state_q <= ST_CRC;
            end
            else
              state_q <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (finish)
          begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
            if (op_q.cmd == FPEC_CMD_PROGRAM)
              page_ld_q <= '0;
          end
        end
        ST_CRC:
        begin
          crc_q <= crc_next;
          crc_addr_q <= crc_addr_q + ADDR_W'(1);
          if (crc_last)
          begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // array, page register, configuration and security bytes
  // no reset on the array: flash contents survive a reset
  always_ff @(posedge clk_in)
  begin
    if (take && is_load)
      page_q[req_pidx] <= req.data;
    if (finish)
    begin
      for (int i = 0; i < ARRAY_BYTES; i++)
      begin
        case (op_q.cmd)
          FPEC_CMD_ERASE_CHIP:
            mem_q[i] <= ERASED_BYTE;
          FPEC_CMD_ERASE_SECTOR:
            if (ADDR_W'(i) >= sec_base && ADDR_W'(i) <= sec_base + SEC_SPAN)
              mem_q[i] <= ERASED_BYTE;
          FPEC_CMD_ERASE_PAGE:
            if (ADDR_W'(i) >= page_base && ADDR_W'(i) <= page_base + PAGE_SPAN)
              mem_q[i] <= ERASED_BYTE;
          FPEC_CMD_ERASE_BYTE:
            if (ADDR_W'(i) == op_q.addr)
              mem_q[i] <= ERASED_BYTE;
          FPEC_CMD_PROGRAM:
            if (ADDR_W'(i) >= page_base && ADDR_W'(i) <= page_base + PAGE_SPAN
                && page_ld_q[i % PAGE_BYTES])
              mem_q[i] <= mem_q[i] & page_q[i % PAGE_BYTES];
          default:
            mem_q[i] <= mem_q[i];
        endcase
      end
      // low two address bits pick the byte; bit 2 picks security bank
      if (op_q.cmd == FPEC_CMD_CFG_ERASE && !op_q.addr[2])
        cfg_q[op_q.addr[1:0]] <= ERASED_BYTE;
      if (op_q.cmd == FPEC_CMD_CFG_WRITE && !op_q.addr[2])
        cfg_q[op_q.addr[1:0]] <= op_q.data;
      if (op_q.cmd == FPEC_CMD_CFG_ERASE && op_q.addr[2])
        sec_q[op_q.addr[1:0]] <= ERASED_BYTE;
      if (op_q.cmd == FPEC_CMD_CFG_WRITE && op_q.addr[2])
        sec_q[op_q.addr[1:0]] <= op_q.data;
      if (op_q.cmd == FPEC_CMD_ERASE_CHIP)
        for (int s = 0; s < SECTOR_COUNT; s++)
          sec_q[s] <= ERASED_BYTE;
    end
  end

  // ==========================================================
  // code read port: bit 0 of a security byte low means secured
  wire rd_secured = ~sec_q[sector_of(code_addr_in)][0];

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      code_data_out <= ERASED_BYTE;
      code_refused_out <= 1'b0;
      power_up_config_byte_out <= ERASED_BYTE;
      fw_stat_out <= '0;
      ser_data_out <= 1'b0;
      ser_data_oe_out <= 1'b0;
    end
    else
    begin
      if (code_rd_in)
      begin
        code_refused_out <= rd_secured;
        code_data_out <= rd_secured ? ERASED_BYTE : mem_q[code_addr_in];
      end
      if (power_on_in)
        power_up_config_byte_out <= cfg_q[0];
      fw_stat_out.busy <= ~idle | take;
      fw_stat_out.done <= done_q;
      fw_stat_out.refused <= refused_q;
      fw_stat_out.crc <= crc_q;
      // serial answer: busy level on the data line while the programmer holds reset and the synchronised serial clock is low
      ser_data_oe_out <= prog_rst_in & ~sclk_s_q;
      ser_data_out <= ~idle;
    end
  end
endmodule // fpec_ctrl

// *** tb/fpec_asserts.sv ***
/*
  Checker for the flash controller's command port, read port and
  power-up byte. Assumes it is bound onto fpec_ctrl, one clock domain.
*/
module fpec_asserts
  import fpec_pkg::*;
#(
  parameter int OP_WAIT = 8
)(
  input wire logic clk_in, // clock
  input wire logic reset_in, // async reset
  input wire logic power_on_in, // power-up pulse
  input wire fpec_pkg::fpec_req_type fw_req_in, // command
  input wire logic fw_valid_in, // strobe
  input wire logic [fpec_pkg::ADDR_W-1:0] fw_addr_hi_lo_in, // address
  input wire fpec_pkg::fpec_stat_type fw_stat_out, // status
  input wire logic prog_rst_in, // programmer reset
  input wire logic ser_clk_in, // serial clock
  input wire logic ser_data_in, // serial data in
  input wire logic ser_data_out, // serial data out
  input wire logic ser_data_oe_out, // serial drive enable
  input wire logic code_rd_in, // read strobe
  input wire logic [fpec_pkg::ADDR_W-1:0] code_addr_in, // read address
  input wire logic [7:0] code_data_out, // read data
  input wire logic code_refused_out, // read refused
  input wire logic [7:0] power_up_config_byte_out // latched byte
);
  import fpec_pkg::*;

  // ==========================================================
  // command timing
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  localparam int DONE_LAT = OP_WAIT + 2;
  fpec_cmd_type cmd_w;
  logic take;
  logic long_op;
  assign cmd_w = fw_req_in.cmd;
  assign take = fw_valid_in && !prog_rst_in && !fw_stat_out.busy;
  assign long_op = !(cmd_w inside {FPEC_CMD_NONE, FPEC_CMD_LOAD,
    FPEC_CMD_CRC_SECTOR, FPEC_CMD_CRC_ALL});
  sequence s_take_op;
    take && long_op;
  endsequence
  sequence s_op_end;
    fw_stat_out.done && !fw_stat_out.busy;
  endsequence

  a_busy_hold: assert property (s_take_op |=> fw_stat_out.busy [*8])
    else $error("busy dropped during an operation");
  a_op_done_time: assert property (s_take_op |-> ##DONE_LAT s_op_end)
    else $error("operation did not end on time");
  a_busy_end: assert property ($fell(fw_stat_out.busy) |-> s_op_end)
    else $error("busy fell without done");
  a_done_pulse: assert property (fw_stat_out.done |=> !fw_stat_out.done)
    else $error("done longer than one cycle");
  a_busy_refuse: assert property (fw_valid_in && !prog_rst_in &&
    fw_stat_out.busy |-> ##2 fw_stat_out.refused)
    else $error("strobe while busy not refused");
  a_load_ack: assert property (take && cmd_w == FPEC_CMD_LOAD
    |-> ##2 fw_stat_out.done)
    else $error("load not acknowledged");
  a_crc_sector: assert property (take && cmd_w == FPEC_CMD_CRC_SECTOR
    |-> ##[256:260] fw_stat_out.done)
    else $error("sector crc late");
  a_secure_blank: assert property (code_refused_out |->
    code_data_out == 8'hFF)
    else $error("refused read leaks data");
  a_cfg_latch: assert property (!$past(power_on_in) |->
    $stable(power_up_config_byte_out))
    else $error("power-up byte changed while running");
  a_ser_quiet: assert property (!$past(prog_rst_in) |-> !ser_data_oe_out)
    else $error("serial data driven outside programming");
endmodule // fpec_asserts

bind fpec_ctrl fpec_asserts #(.OP_WAIT(OP_WAIT)) fpec_asserts_inst (
  .clk_in, .reset_in, .power_on_in, .fw_req_in, .fw_valid_in,
  .fw_addr_hi_lo_in, .fw_stat_out, .prog_rst_in, .ser_clk_in,
  .ser_data_in, .ser_data_out, .ser_data_oe_out, .code_rd_in,
  .code_addr_in, .code_data_out, .code_refused_out,
  .power_up_config_byte_out
);

// *** tb/fpec_ser_prog.sv ***
/*
  Serial programmer model: holds reset, shifts 22-bit frames msb first.
  Assumes the bench clock paces the serial clock.
*/
module fpec_ser_prog (
  input wire logic clk_in, // bench clock
  input wire logic dut_data_in, // controller data out
  input wire logic dut_oe_in, // controller drive enable
  output logic prog_rst_out, // held reset pin
  output logic ser_clk_out, // serial clock, still between frames
  output logic line_out // resolved data line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_en = 1'b0;
  logic drv_bit = 1'b0;
  logic last_q = 1'b0;
  initial prog_rst_out = 1'b0;
  initial ser_clk_out = 1'b0;
  // released line has no pull: toggle so a stale value never passes
  assign line_out = drv_en ? drv_bit : dut_oe_in ? dut_data_in : ~last_q;
  always @(posedge clk_in) last_q <= line_out;

  task automatic send(input logic [21:0] frame);
    prog_rst_out <= 1'b1;
    drv_en <= 1'b1;
    for (int i = 21; i >= 0; i--)
    begin
      drv_bit <= frame[i];
      repeat (5) @(posedge clk_in);
      ser_clk_out <= 1'b1;
      repeat (5) @(posedge clk_in);
      ser_clk_out <= 1'b0;
    end
    drv_en <= 1'b0;
  endtask

  task automatic stop();
    prog_rst_out <= 1'b0;
  endtask
endmodule // fpec_ser_prog

// *** tb/test_flash_program_erase_control.sv ***
/*
  Self-checking bench for fpec_ctrl: erase, program, crc, security,
  power-up byte and the serial path. Assumes OP_WAIT shortened to 8.
*/
module test_flash_program_erase_control;
  timeunit 1ns;
  timeprecision 1ns;
  import fpec_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic power_on = 1'b0;
  logic valid = 1'b0;
  logic code_rd = 1'b0;
  logic rd_d = 1'b0;
  logic pw_d = 1'b0;
  logic crc_pend = 1'b0;
  fpec_req_type req = '0;
  logic [9:0] addr = '0;
  logic [9:0] code_addr = '0;
  fpec_stat_type st;
  logic ser_clk, prog_rst, line, dout, doe, code_ref;
  logic [7:0] code_data, pcfg;
  logic [7:0] mem [1024];
  logic lock [4] = '{default: 1'b0};
  logic [39:0] expq [$];
  int err_count = 0;
  int num_checks = 0;

  initial forever #10 clk_in = ~clk_in;

  fpec_ctrl #(.OP_WAIT(8)) fpec_ctrl_inst (
    .clk_in(clk_in), .reset_in(reset_in), .power_on_in(power_on),
    .fw_req_in(req), .fw_valid_in(valid), .fw_addr_hi_lo_in(addr),
    .fw_stat_out(st), .prog_rst_in(prog_rst), .ser_clk_in(ser_clk),
    .ser_data_in(line), .ser_data_out(dout), .ser_data_oe_out(doe),
    .code_rd_in(code_rd), .code_addr_in(code_addr),
    .code_data_out(code_data), .code_refused_out(code_ref),
    .power_up_config_byte_out(pcfg));
  fpec_ser_prog fpec_ser_prog_inst (.clk_in(clk_in), .dut_data_in(dout),
    .dut_oe_in(doe), .prog_rst_out(prog_rst), .ser_clk_out(ser_clk),
    .line_out(line));

  // ==========================================================
  // result watcher
  task automatic end_sim();
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic void chk(logic [39:0] got);
    logic [39:0] e;
    num_checks++;
    e = (expq.size() > 0) ? expq.pop_front() : ~got;
    if (got !== e)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, e);
    end
  endfunction

  always @(posedge clk_in)
  begin
    rd_d <= code_rd;
    pw_d <= power_on;
    if (rd_d) chk({31'h0, code_ref, code_data});
    if (pw_d) chk({32'h0, pcfg});
    if (st.done === 1'b1 && crc_pend) chk({8'h0, st.crc});
    if (st.done === 1'b1 && prog_rst === 1'b1)
      chk({38'h0, doe, dout});
    if (st.refused === 1'b1) chk(40'hFF00000000);
  end

  // ==========================================================
  // drivers
  task automatic wait_done();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (st.done !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic cmd(fpec_cmd_type c, int a, logic [7:0] d, bit intr = 0);
    req <= '{c, a[9:0], d};
    addr <= a[9:0];
    valid <= 1'b1;
    @(posedge clk_in);
    valid <= 1'b0;
    if (intr)
    begin
      repeat (3) @(posedge clk_in);
      expq.push_back(40'hFF00000000);
      req.cmd <= FPEC_CMD_ERASE_CHIP;
      valid <= 1'b1;
      @(posedge clk_in);
      valid <= 1'b0;
    end
    wait_done();
  endtask

  task automatic rd(int a);
    expq.push_back(lock[a/256] ? 40'h1FF : {32'h0, mem[a]});
    code_addr <= a[9:0];
    code_rd <= 1'b1;
    @(posedge clk_in);
    code_rd <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic prog_byte(int a, logic [7:0] v);
    cmd(FPEC_CMD_LOAD, a, v);
    cmd(FPEC_CMD_PROGRAM, a, 8'h00);
    mem[a] = mem[a] & v;
  endtask

  function automatic logic [31:0] crc_of(int lo, int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = lo; i < lo + n; i++)
    begin
      c = c ^ {mem[i], 24'h0};
      for (int b = 0; b < 8; b++)
        c = c[31] ? {c[30:0], 1'b0} ^ CRC_POLY : {c[30:0], 1'b0};
    end
    return c;
  endfunction

  task automatic crc(fpec_cmd_type c, int lo, int n);
    crc_pend <= 1'b1;
    expq.push_back({8'h0, crc_of(lo, n)});
    cmd(c, lo, 8'h00);
    crc_pend <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int p, s, k, a, a2;
    logic [7:0] v;
    void'($urandom(32'hE135));
    for (int i = 0; i < 1024; i++) mem[i] = 8'hFF;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    cmd(FPEC_CMD_ERASE_CHIP, 0, 8'h00);
    for (int i = 0; i < 8; i++) cmd(FPEC_CMD_CFG_ERASE, i, 8'h00);
    v = 8'($urandom);
    cmd(FPEC_CMD_CFG_WRITE, 0, v);
    expq.push_back({32'h0, v});
    power_on <= 1'b1;
    @(posedge clk_in);
    power_on <= 1'b0;
    @(posedge clk_in);
    cmd(FPEC_CMD_CFG_WRITE, 0, 8'h00);
    p = $urandom_range(63);
    s = p / 16;
    k = $urandom_range(16, 1);
    for (int i = 0; i < k; i++)
    begin
      mem[p*16+i] = 8'($urandom);
      cmd(FPEC_CMD_LOAD, p*16+i, mem[p*16+i]);
    end
    cmd(FPEC_CMD_PROGRAM, p*16, 8'h00);
    for (int i = 0; i < 16; i++) rd(p*16+i);
    crc(FPEC_CMD_CRC_SECTOR, s*256, 256);
    crc(FPEC_CMD_CRC_ALL, 0, 1024);
    a = p*16 + k - 1;
    cmd(FPEC_CMD_ERASE_BYTE, a, 8'h00);
    mem[a] = 8'hFF;
    rd(a);
    rd(p*16);
    cmd(FPEC_CMD_ERASE_PAGE, p*16, 8'h00);
    for (int i = 0; i < 16; i++) mem[p*16+i] = 8'hFF;
    rd(p*16);
    a2 = (s ^ 1)*256 + $urandom_range(255);
    prog_byte(p*16 + 5, 8'($urandom));
    prog_byte(a2, 8'($urandom));
    cmd(FPEC_CMD_ERASE_SECTOR, s*256, 8'h00, 1);
    for (int i = 0; i < 256; i++) mem[s*256+i] = 8'hFF;
    rd(p*16 + 5);
    rd(a2);
    cmd(FPEC_CMD_CFG_WRITE, 4 + (s ^ 1), 8'hFE);
    lock[s^1] = 1'b1;
    rd(a2);
    rd(s*256);
    cmd(FPEC_CMD_CFG_ERASE, 4 + (s ^ 1), 8'h00);
    lock[s^1] = 1'b0;
    rd(a2);
    prog_byte(a2 ^ 1, 8'h5A);
    fpec_ser_prog_inst.send({FPEC_CMD_ERASE_BYTE, 10'(a2 ^ 1), 8'h00});
    // line driven, showing idle, once the serial erase is done
    expq.push_back(40'h2);
    wait_done();
    fpec_ser_prog_inst.stop();
    mem[a2^1] = 8'hFF;
    repeat (2) @(posedge clk_in);
    rd(a2 ^ 1);
    repeat (2) @(posedge clk_in);
    if (expq.size() != 0) err_count++;
    end_sim();
  end
endmodule // test_flash_program_erase_control
